/* File: hdl/oprg_defs.svh */
`ifndef OPRG_DEFS_SVH
`define OPRG_DEFS_SVH
`define OPRG_CLK_HZ       10000000
// Pulse widths and setup time in microseconds.
`define OPRG_TPW_US       200
`define OPRG_TOPW_US      600
`define OPRG_TSET_US      2
`define OPRG_PW_CYC       ((`OPRG_TPW_US * (`OPRG_CLK_HZ / 1000000)))
`define OPRG_OPW_CYC      ((`OPRG_TOPW_US * (`OPRG_CLK_HZ / 1000000)))
`define OPRG_SET_CYC      ((`OPRG_TSET_US * (`OPRG_CLK_HZ / 1000000)))
`define OPRG_ROM_TOP      17'h07FFF
`define OPRG_ERASED       8'hFF
`define OPRG_MAX_TRY      25
`endif

/* File: hdl/oprg_pkg.sv */
package oprg_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_PULSE = 3'b010,
    ST_GAP   = 3'b011,
    ST_VRFY  = 3'b100,
    ST_OVER  = 3'b101,
    ST_DONE  = 3'b110
  } oprg_state_t;
endpackage : oprg_pkg

/* File: hdl/oprg_programmer.sv */
// Functional notes
// R1: CE low, OE high, pulse low writes the data byte at the address.
// R2: CE low, OE low, pulse high makes the device drive stored data.
// R3: Other strobe combinations inhibit writing; data pins float. The code drives them in ST_GAP and in ST_SETUP after its first cycle.
// R4: Write exactly one byte per programming cycle, never page mode.
// R5: Only addresses 0x0000 to 0x7FFF are ever programmed.
// R6: Image bytes above the ROM must be 0xFF.
// R7: Initial program pulse lasts 0.19 to 0.21 ms, nominally 0.20 ms.
// R8: Over-programming pulse lasts between 0.19 ms and 5.25 ms.
// R9: Write failures at consecutive addresses stop the run.
// R10: Pulse and verify until match, bounded retries, then over-program.
`timescale 1ns/1ns
`include "oprg_defs.svh"
module oprg_programmer
  import oprg_pkg::*;
#(
  parameter int PW_CYC  = `OPRG_PW_CYC,
  parameter int OPW_CYC = `OPRG_OPW_CYC,
  parameter int MAX_TRY = `OPRG_MAX_TRY
) (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        reqValid,
  output logic             reqReady,
  input  wire logic [16:0] reqAddr,
  input  wire logic [7:0]  reqData,
  output logic             rspValid,
  input  wire logic        rspReady,
  output logic [16:0]      rspAddr,
  output logic             rspOk,
  output logic             runAborted,
  output logic             chipEnableN,
  output logic             outEnableN,
  output logic             program_pulse_n,
  output logic [16:0]      byte_address_pins,
  output logic [7:0]       byteDataOut,
  output logic             byteDataOe,
  input  wire logic [7:0]  byteDataIn
);
  localparam int SET_CYC = `OPRG_SET_CYC;
  localparam int CW      = 16;

  oprg_state_t       state_ff, nxt_state;
  logic [CW-1:0]     cnt_ff, nxt_cnt;
  logic [7:0]        try_ff, nxt_try;
  logic [16:0]       addr_ff, nxt_addr;
  logic [7:0]        data_ff, nxt_data;
  logic              fail_ff, nxt_fail;
  logic              prevFail_ff, nxt_prevFail;
  logic              abort_ff, nxt_abort;
  logic              over_ff, nxt_over;
  logic [7:0]        sync1_ff, sync2_ff;
  logic              rspPush, rspPushOk;
  logic [1:0]        bufCnt_ff, nxt_bufCnt;
  logic [17:0]       buf_ff [2];
  logic [17:0]       nxt_buf [2];

  // Read data crosses from the pins, so it is synchronised before compare.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sync1_ff <= 8'h00;
      sync2_ff <= 8'h00;
    end else begin
      sync1_ff <= byteDataIn;
      sync2_ff <= sync1_ff;
    end
  end

  function automatic logic inRom(input logic [16:0] a);
    inRom = (a <= `OPRG_ROM_TOP);
  endfunction : inRom

  assign reqReady = (state_ff == ST_IDLE) && !abort_ff;

  always_comb begin
    nxt_state    = state_ff;
    nxt_cnt      = cnt_ff;
    nxt_try      = try_ff;
    nxt_addr     = addr_ff;
    nxt_data     = data_ff;
    nxt_fail     = fail_ff;
    nxt_prevFail = prevFail_ff;
    nxt_abort    = abort_ff;
    nxt_over     = over_ff;
    rspPush      = 1'b0;
    rspPushOk    = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (reqValid && reqReady) begin
          nxt_addr = reqAddr;
          nxt_data = reqData;
          nxt_try  = 8'h00;
          nxt_cnt  = '0;
          nxt_fail = 1'b0;
          nxt_over = 1'b0;
          // R5 range limit
          // R6 erased image
          if (!inRom(reqAddr)) begin
            nxt_fail  = (reqData != `OPRG_ERASED);
            nxt_state = ST_DONE;
          end else begin
            nxt_state = ST_SETUP;
          end
        end
      end
      ST_SETUP: begin
        // One extra cycle lets the device release the pins after a read.
        nxt_cnt = cnt_ff + 1'b1;
        if (cnt_ff == CW'(SET_CYC)) begin
          nxt_cnt   = '0;
          nxt_state = over_ff ? ST_OVER : ST_PULSE;
        end
      end
      ST_PULSE: begin
        // R7 pulse width
        nxt_cnt = cnt_ff + 1'b1;
        if (cnt_ff == CW'(PW_CYC - 1)) begin
          nxt_cnt   = '0;
          nxt_try   = try_ff + 1'b1;
          nxt_state = ST_GAP;
        end
      end
      ST_GAP: begin
        nxt_cnt = cnt_ff + 1'b1;
        if (cnt_ff == CW'(SET_CYC - 1)) begin
          nxt_cnt   = '0;
          nxt_state = ST_VRFY;
        end
      end
      ST_VRFY: begin
        // R10 verify loop
        nxt_cnt = cnt_ff + 1'b1;
        if (cnt_ff == CW'(SET_CYC + 1)) begin
          nxt_cnt = '0;
          if (sync2_ff == data_ff) begin
            nxt_over  = 1'b1;
            nxt_state = ST_SETUP;
          end else if (try_ff >= 8'(MAX_TRY)) begin
            nxt_fail  = 1'b1;
            nxt_state = ST_DONE;
          end else begin
            nxt_state = ST_SETUP;
          end
        end
      end
      ST_OVER: begin
        // R8 overprogram width
        nxt_cnt = cnt_ff + 1'b1;
        if (cnt_ff == CW'(OPW_CYC - 1)) begin
          nxt_cnt   = '0;
          nxt_state = ST_DONE;
        end
      end
      ST_DONE: begin
        rspPush   = 1'b1;
        rspPushOk = !fail_ff;
        if (bufCnt_ff != 2'd2) begin
          nxt_prevFail = fail_ff;
          // R9 consecutive stop
          if (fail_ff && prevFail_ff) begin
            nxt_abort = 1'b1;
          end
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_ff    <= ST_IDLE;
      cnt_ff      <= '0;
      try_ff      <= 8'h00;
      addr_ff     <= 17'h00000;
      data_ff     <= 8'h00;
      fail_ff     <= 1'b0;
      prevFail_ff <= 1'b0;
      abort_ff    <= 1'b0;
      over_ff     <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      cnt_ff      <= nxt_cnt;
      try_ff      <= nxt_try;
      addr_ff     <= nxt_addr;
      data_ff     <= nxt_data;
      fail_ff     <= nxt_fail;
      prevFail_ff <= nxt_prevFail;
      abort_ff    <= nxt_abort;
      over_ff     <= nxt_over;
    end
  end

  // Two-entry result buffer; a stalled consumer holds the sequencer in ST_DONE once both entries are full.
  logic doPush, doPop;
  assign doPush = rspPush && (bufCnt_ff != 2'd2);
  assign doPop  = rspReady && (bufCnt_ff != 2'd0);
  always_comb begin
    nxt_buf[0] = buf_ff[0];
    nxt_buf[1] = buf_ff[1];
    nxt_bufCnt = bufCnt_ff;
    if (doPop) begin
      nxt_buf[0] = buf_ff[1];
      nxt_bufCnt = bufCnt_ff - 2'd1;
    end
    if (doPush) begin
      nxt_buf[nxt_bufCnt[0]] = {rspPushOk, addr_ff};
      nxt_bufCnt = nxt_bufCnt + 2'd1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      bufCnt_ff <= 2'd0;
      buf_ff[0] <= 18'h00000;
      buf_ff[1] <= 18'h00000;
    end else begin
      bufCnt_ff <= nxt_bufCnt;
      buf_ff[0] <= nxt_buf[0];
      buf_ff[1] <= nxt_buf[1];
    end
  end
  assign rspValid   = (bufCnt_ff != 2'd0);
  assign rspAddr    = buf_ff[0][16:0];
  assign rspOk      = buf_ff[0][17];
  assign runAborted = abort_ff;

  // R1 write strobes
  // R2 verify strobes
  // R3 inhibit float
  // R4 single byte
  always_comb begin
    chipEnableN     = !(state_ff inside {ST_SETUP, ST_PULSE, ST_GAP,
                                         ST_VRFY, ST_OVER});
    outEnableN      = (state_ff != ST_VRFY);
    program_pulse_n = !(state_ff inside {ST_PULSE, ST_OVER});
    // Driving at once after a verify read would fight the device's output.
    byteDataOe      = (state_ff inside {ST_SETUP, ST_PULSE, ST_GAP,
                                        ST_OVER}) &&
                      !(state_ff == ST_SETUP && cnt_ff == '0);
  end
  assign byte_address_pins = addr_ff;
  assign byteDataOut       = data_ff;

  property p_pulse_width;
    @(posedge clk_sys) disable iff (!rstn)
      $fell(program_pulse_n) && state_ff == ST_PULSE |->
        !program_pulse_n [*8];
  endproperty
  a_pulse_width: assert property (p_pulse_width) // R7
    else $error("Program pulse shorter than expected.");

  property p_no_drive_verify;
    @(posedge clk_sys) disable iff (!rstn)
      !outEnableN |-> !byteDataOe && program_pulse_n && !chipEnableN;
  endproperty
  a_no_drive_verify: assert property (p_no_drive_verify) // R2
    else $error("Data driven during verify.");

  property p_write_strobes;
    @(posedge clk_sys) disable iff (!rstn)
      !program_pulse_n |-> outEnableN && !chipEnableN && byteDataOe;
  endproperty
  a_write_strobes: assert property (p_write_strobes) // R1
    else $error("Bad strobes during program pulse.");

  property p_range;
    @(posedge clk_sys) disable iff (!rstn)
      !chipEnableN |-> byte_address_pins <= `OPRG_ROM_TOP;
  endproperty
  a_range: assert property (p_range) // R5
    else $error("Programming outside ROM range.");

  property p_abort_stops;
    @(posedge clk_sys) disable iff (!rstn)
      runAborted |-> !reqReady ##1 runAborted;
  endproperty
  a_abort_stops: assert property (p_abort_stops) // R9
    else $error("Run continued after abort.");

  sequence s_ce_held;
    !chipEnableN ##1 !chipEnableN;
  endsequence
  property p_one_byte;
    @(posedge clk_sys) disable iff (!rstn)
      s_ce_held |-> $stable(byte_address_pins) && $stable(byteDataOut);
  endproperty
  a_one_byte: assert property (p_one_byte) // R4
    else $error("Address or data changed inside a byte cycle.");
endmodule : oprg_programmer

/* File: verification/oprg_rom_model.sv */
`timescale 1ns/1ns
module oprg_rom_model #(
  parameter int T_OE = 150,
  parameter int T_DF = 130
) (
  input  wire logic        chipEnableN,
  input  wire logic        outEnableN,
  input  wire logic        program_pulse_n,
  input  wire logic [16:0] byte_address_pins,
  input  wire logic [7:0]  byte_data_pins,
  input  wire logic        breakWrites,
  output logic [7:0]       devData,
  output logic             devOe
);
  logic [7:0] romMem [0:32767];
  time        pulseStart = 0;
  time        prevPw = 0;
  time        lastPw = 0;
  int         pulseCnt = 0;
  initial begin
    foreach (romMem[i]) romMem[i] = 8'hFF;
  end
  always @(negedge program_pulse_n) pulseStart = $time;
  // one byte per pulse, nothing above the ROM
  always @(posedge program_pulse_n) begin
    prevPw = lastPw;
    lastPw = $time - pulseStart;
    pulseCnt = pulseCnt + 1;
    // Cells only clear, so a failed cell keeps the erased level.
    if (!chipEnableN && outEnableN && !breakWrites &&
        byte_address_pins[16:15] == 2'b00) begin
      romMem[byte_address_pins[14:0]] &= byte_data_pins;
    end
  end
  // drive only in verify
  // Output turns on after the access delay and lets go after the float delay.
  assign #(T_OE, T_DF) devOe = !chipEnableN && !outEnableN &&
                               program_pulse_n;
  assign devData = romMem[byte_address_pins[14:0]];
endmodule : oprg_rom_model

/* File: verification/test_oprg_programmer.sv */
`timescale 1ns/1ns
module test_oprg_programmer;
  localparam int PW  = 10;
  localparam int OPW = 10;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic        reqValid = 1'b0;
  logic [16:0] reqAddr = 17'h00000;
  logic [7:0]  reqData = 8'h00;
  logic        rspReady = 1'b0;
  logic        breakWrites = 1'b0;
  logic        reqReady, rspValid, rspOk, runAborted, byteDataOe, devOe;
  logic        chipEnableN, outEnableN, program_pulse_n;
  logic [16:0] rspAddr, byte_address_pins;
  logic [7:0]  byteDataOut, devData;
  logic [7:0]  lastPins = 8'h00;
  wire  [7:0]  pinLevel;
  int          n_fail = 0;
  int          tests_run = 0;
  // A floating bus shows the inverse of its last level.
  assign pinLevel = byteDataOe ? byteDataOut : devOe ? devData : ~lastPins;
  always #50 clk_sys = ~clk_sys;
  oprg_programmer #(.PW_CYC(PW), .OPW_CYC(OPW), .MAX_TRY(2)) i_dut (
    .clk_sys, .rstn, .reqValid, .reqReady, .reqAddr, .reqData, .rspValid,
    .rspReady, .rspAddr, .rspOk, .runAborted, .chipEnableN, .outEnableN,
    .program_pulse_n, .byte_address_pins, .byteDataOut, .byteDataOe,
    .byteDataIn(pinLevel));
  oprg_rom_model i_rom (.chipEnableN, .outEnableN, .program_pulse_n,
    .byte_address_pins, .byte_data_pins(pinLevel), .breakWrites, .devData,
    .devOe);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  always @(posedge clk_sys) begin
    if (byteDataOe || devOe) lastPins <= pinLevel;
    if (devOe) chk(byteDataOe, 1'b0);
  end
  task automatic send(input logic [16:0] a, input logic [7:0] d);
    int k;
    k = 0;
    reqAddr <= a;
    reqData <= d;
    reqValid <= 1'b1;
    do begin
      @(posedge clk_sys);
      k++;
    end while (reqReady !== 1'b1 && k < 50);
    chk(reqReady, 1'b1);
    reqValid <= 1'b0;
  endtask : send
  task automatic take(input logic [16:0] a, input logic ok);
    int k;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (rspValid !== 1'b1 && k < 1000);
    chk(rspValid, 1'b1);
    chk(rspAddr, a);
    chk(rspOk, ok);
    rspReady <= 1'b1;
    @(posedge clk_sys);
    rspReady <= 1'b0;
  endtask : take
  task automatic t_byte(input logic [16:0] a, input logic [7:0] d);
    int c;
    c = i_rom.pulseCnt;
    send(a, d);
    take(a, 1'b1);
    chk(i_rom.romMem[a[14:0]], d);
    chk(i_rom.prevPw, PW * 100);
    chk(i_rom.lastPw, OPW * 100);
    chk(i_rom.pulseCnt - c, 2);
  endtask : t_byte
  task automatic t_outside();
    int c;
    c = i_rom.pulseCnt;
    send(17'h08000, 8'hFF);
    take(17'h08000, 1'b1);
    @(posedge clk_sys);
    send(17'h1FFFF, 8'h12);
    take(17'h1FFFF, 1'b0);
    chk(i_rom.pulseCnt, c);
  endtask : t_outside
  task automatic t_stall();
    send(17'h0A000, 8'hFF);
    @(posedge clk_sys);
    send(17'h0B000, 8'hFF);
    repeat (10) @(posedge clk_sys);
    chk(rspValid, 1'b1);
    take(17'h0A000, 1'b1);
    take(17'h0B000, 1'b1);
  endtask : t_stall
  task automatic t_abort();
    breakWrites <= 1'b1;
    send(17'h00100, 8'h00);
    take(17'h00100, 1'b0);
    @(posedge clk_sys);
    send(17'h00101, 8'h00);
    take(17'h00101, 1'b0);
    chk(runAborted, 1'b1);
    chk(reqReady, 1'b0);
    chk(i_rom.romMem[15'h0100], 8'hFF);
  endtask : t_abort
  task automatic close_out();
    $display("Mismatches %0d of %0d checks", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out
  // The span is about thirty-five times what the scenarios need.
  initial begin
    #2000000;
    n_fail++;
    close_out();
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    t_byte(17'h00005, 8'h5A);
    t_byte(17'h07FFF, 8'h00);
    t_outside();
    t_stall();
    t_abort();
    close_out();
  end
endmodule : test_oprg_programmer
